// [pkg/ecs_pkg.sv]
// ----------------------------------------------------------------------------
// shared constants and types of the configuration store controller
// ----------------------------------------------------------------------------
package ecs_pkg;

    // ------------------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------------------
    localparam int SEG_N = 23;                  // entries in the segment list
    localparam int ADDR_W = 12;                 // register address width
    localparam int NV_AW = 11;                  // nonvolatile store address width
    localparam int IDX_W = 5;                   // segment index width
    localparam int CNT_W = 7;                   // byte count field width

    // ------------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------------
    localparam logic [11:0] ADR_STATUS_ROUTE = 12'h01D;   // status pin routing
    localparam logic [11:0] ADR_SOFT_SYNC = 12'h230;      // soft sync
    localparam logic [11:0] ADR_COMMIT = 12'h232;         // commit_buffered_settings
    localparam logic [11:0] ADR_SEG_FIRST = 12'hA00;      // store_segment_list first
    localparam logic [11:0] ADR_SEG_LAST = 12'hA16;       // store_segment_list last
    localparam logic [11:0] ADR_XFER_STATUS = 12'hB00;    // store_transfer_status
    localparam logic [11:0] ADR_DATA_ERR = 12'hB01;       // store_data_error
    localparam logic [11:0] ADR_RST_WREN = 12'hB02;       // store_reset_and_write_enable
    localparam logic [11:0] ADR_STORE_TRIG = 12'hB03;     // store_write_trigger

    // ------------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------------
    localparam int BIT_ROUTE = 7;               // status pin shows pending flag
    localparam int BIT_FLAG = 0;                // single flag bits
    localparam int BIT_SOFT_RST = 1;            // soft reset from store
    localparam int BIT_WREN = 0;                // store write enable

    // ------------------------------------------------------------------------
    // segment entry encodings
    // ------------------------------------------------------------------------
    localparam logic [7:0] OP_APPLY = 8'h80;    // apply-settings opcode
    localparam logic [7:0] OP_END = 8'hFF;      // end-of-data opcode
    localparam int BIT_OPCODE = 7;              // 0: range entry, 1: opcode

    // default list: five ranges covering 0x000..0x232, apply, end
    localparam logic [SEG_N-1:0][7:0] SEG_DEFAULT = {
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        OP_END, OP_APPLY,
        8'h00, 8'h02, 8'h32,
        8'h80, 8'h01, 8'h7F,
        8'h00, 8'h01, 8'h7F,
        8'h80, 8'h00, 8'h7F,
        8'h00, 8'h00, 8'h7F
    };

    // ------------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------------
    localparam logic RST_WREN = 1'b0;           // store write protected
    localparam logic RST_ROUTE = 1'b0;          // status pin not routed
    localparam logic RST_SOFT_SYNC = 1'b0;      // outputs not held

    // ------------------------------------------------------------------------
    // sequencer states and module state
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_NV, ST_BUFW, ST_DONE} ecs_seq_t;

    typedef struct packed {
        ecs_seq_t st;                           // sequencer state
        logic [SEG_N-1:0][7:0] seg;             // segment list
        logic [IDX_W-1:0] idx;                  // current entry
        logic [CNT_W-1:0] cnt;                  // bytes left minus one
        logic dir_store;                        // 1: buffer to store
        logic [ADDR_W-1:0] buf_addr;            // buffer bank address
        logic [NV_AW-1:0] nv_addr;              // store address
        logic [7:0] data;                       // byte in flight
        logic commit;                           // commit bit
        logic active_load;                      // copy pulse
        logic route;                            // status pin routing
        logic soft_sync;                        // soft sync bit
        logic sync_trig;                        // sync trigger pulse
        logic wren;                             // store write enable
        logic soft_rst;                         // soft reset bit
        logic soft_pulse;                       // soft reset pulse
        logic restore_req;                      // restore waiting to start
        logic store;                            // store trigger bit
        logic err;                              // data error flag
        logic [7:0] rdata;                      // register read data
        logic sclk_s1;                          // serial clock synchroniser
        logic sclk_s2;
        logic sclk_s3;                          // edge detect history
        logic sel_s1;                           // store-select pin synchroniser
        logic sel_s2;
    } ecs_regs_t;

endpackage : ecs_pkg

// [sim/ecs_nv_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// nonvolatile store model: answers each request after a few cycles
// ----------------------------------------------------------------------------
module ecs_nv_model (
    input wire logic mclk,
    input wire logic nv_req,
    input wire logic nv_we,
    input wire logic [10:0] nv_addr,
    input wire logic [7:0] nv_wdata,
    input wire logic bad,
    output logic [7:0] nv_rdata,
    output logic nv_ack,
    output logic nv_err
);
    logic [7:0] mem [0:2047]; // store cells
    int wait_n = 0; // cycles the current request has waited
    int writes = 0; // bytes written so far
    initial begin
        nv_rdata = 8'h00;
        nv_ack = 1'b0;
        nv_err = 1'b0;
    end
    // slow answer; read data toggles outside the answer cycle so stale bytes never pass
    always @(posedge mclk) begin
        nv_ack <= 1'b0;
        nv_err <= 1'b0;
        nv_rdata <= ~nv_rdata;
        if (nv_req && !nv_ack && wait_n >= 2) begin
            nv_ack <= 1'b1;
            nv_err <= bad;
            wait_n <= 0;
            if (nv_we) begin
                mem[nv_addr] <= nv_wdata;
                writes <= writes + 1;
            end else begin
                nv_rdata <= mem[nv_addr];
            end
        end else begin
            wait_n <= (nv_req && !nv_ack) ? wait_n + 1 : 0;
        end
    end
endmodule : ecs_nv_model

// [sim/tb.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// testbench: the bench plays the host, the model plays the store
// ----------------------------------------------------------------------------
module tb;
    import ecs_pkg::*;
    logic mclk = 0, rst = 1, sclk = 0, sel_n = 1, wr = 0, rd = 0, bad = 0, other = 1;
    logic [11:0] addr = 12'h000, ba, lba;
    logic [7:0] wd = 8'h00, rdat, bwd, nrd, nwd, lbw;
    logic [10:0] na;
    logic bwe, nreq, nwe, nack, nerr, al, srp, sh, st, sp, xp;
    int fail_count = 0, checks_done = 0, nal = 0, nsr = 0, nst = 0, nbw = 0;
    always #5 mclk = ~mclk;
    ecs_ctrl u_dut (.mclk(mclk), .rst(rst), .sclk(sclk), .store_sel_n(sel_n), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat), .buf_addr(ba), .buf_rdata(ba[7:0] ^ 8'h5A),
        .buf_wdata(bwd), .buf_we(bwe), .nv_req(nreq), .nv_we(nwe), .nv_addr(na), .nv_wdata(nwd),
        .nv_rdata(nrd), .nv_ack(nack), .nv_err(nerr), .active_load(al), .soft_rst_pulse(srp),
        .sync_hold(sh), .sync_trig(st), .status_other(other), .status_pin(sp), .xfer_pending(xp));
    ecs_nv_model u_nv (.mclk(mclk), .nv_req(nreq), .nv_we(nwe), .nv_addr(na), .nv_wdata(nwd), .bad(bad),
        .nv_rdata(nrd), .nv_ack(nack), .nv_err(nerr));
    // pulse counters
    always @(posedge mclk) begin
        nal <= nal + int'(al === 1'b1);
        nsr <= nsr + int'(srp === 1'b1);
        nst <= nst + int'(st === 1'b1);
        nbw <= nbw + int'(bwe === 1'b1);
        // last buffer byte written and where it went
        if (bwe === 1'b1) begin
            lbw <= bwd;
            lba <= ba;
        end
    end
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task w(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk) begin wr <= 1; addr <= a; wd <= d; end
        @(posedge mclk) wr <= 0;
    endtask : w
    task r(input string n, input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk) begin rd <= 1; addr <= a; end
        @(posedge mclk) rd <= 0;
        @(posedge mclk) #1 chk(n, 16'(e), 16'(rdat));
    endtask : r
    task sclk_tick;
        @(posedge mclk);
        sclk <= 1;
        repeat (4) @(posedge mclk);
        sclk <= 0;
        repeat (4) @(posedge mclk);
    endtask : sclk_tick
    task wait_idle;
        for (int i = 0; i < 5000 && xp !== 1'b0; i++) @(posedge mclk);
        chk("xfer_pending", 16'h0, 16'(xp));
    endtask : wait_idle
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task t_reset;
        r("pending", ADR_XFER_STATUS, 8'h00);
        r("error", ADR_DATA_ERR, 8'h00);
        r("write enable", ADR_RST_WREN, 8'h00);
        @(posedge mclk) other <= 1'b0;
        #1 chk("status_pin", 16'h0, 16'(sp));
        @(posedge mclk) other <= 1'b1;
        w(ADR_STORE_TRIG, 8'h01);
        r("store refused", ADR_STORE_TRIG, 8'h00);
        chk("store writes", 16'h0, 16'(u_nv.writes));
    endtask : t_reset
    task t_commit;
        w(ADR_COMMIT, 8'h01);
        repeat (4) @(posedge mclk);
        chk("no copy before sclk", 16'h0, 16'(nal));
        sclk_tick;
        chk("copy pulses", 16'h1, 16'(nal));
        r("commit cleared", ADR_COMMIT, 8'h00);
    endtask : t_commit
    task t_store_default;
        w(ADR_RST_WREN, 8'h01);
        w(ADR_STORE_TRIG, 8'h01);
        r("store busy", ADR_STORE_TRIG, 8'h01);
        r("pending busy", ADR_XFER_STATUS, 8'h01);
        wait_idle;
        chk("default bytes", 16'd563, 16'(u_nv.writes));
        chk("apply pulses", 16'h2, 16'(nal));
        r("store done", ADR_STORE_TRIG, 8'h00);
        r("error clear", ADR_DATA_ERR, 8'h00);
    endtask : t_store_default
    task t_store_list;
        w(ADR_SEG_FIRST, 8'h01);
        w(ADR_SEG_FIRST + 12'h001, 8'h00);
        w(ADR_SEG_FIRST + 12'h002, 8'h10);
        w(ADR_SEG_FIRST + 12'h003, OP_END);
        w(ADR_STATUS_ROUTE, 8'h80);
        w(ADR_STORE_TRIG, 8'h01);
        repeat (3) @(posedge mclk);
        #1 chk("routed busy", 16'h1, 16'(sp));
        wait_idle;
        #1 chk("routed done", 16'h0, 16'(sp));
        chk("list bytes", 16'd565, 16'(u_nv.writes));
        chk("first byte", 16'h004A, 16'(u_nv.mem[0]));
        chk("second byte", 16'h004B, 16'(u_nv.mem[1]));
        chk("no apply", 16'h2, 16'(nal));
        // write enable dropped while the store runs: abort with error
        w(ADR_STORE_TRIG, 8'h01);
        w(ADR_RST_WREN, 8'h00);
        wait_idle;
        chk("aborted writes", 16'd565, 16'(u_nv.writes));
        r("abort error", ADR_DATA_ERR, 8'h01);
        r("abort store clear", ADR_STORE_TRIG, 8'h00);
    endtask : t_store_list
    task t_restore;
        w(ADR_RST_WREN, 8'h02);
        repeat (2) @(posedge mclk);
        chk("no reset with select high", 16'h0, 16'(nsr));
        @(posedge mclk);
        bad <= 1;
        sel_n <= 0;
        repeat (4) @(posedge mclk);
        w(ADR_RST_WREN, 8'h02);
        repeat (2) @(posedge mclk);
        chk("soft reset pulse", 16'h1, 16'(nsr));
        r("soft bit held", ADR_RST_WREN, 8'h02);
        sclk_tick;
        r("soft bit cleared", ADR_RST_WREN, 8'h00);
        wait_idle;
        chk("restored bytes", 16'h2, 16'(nbw));
        chk("restored data", 16'h004B, 16'(lbw));
        chk("restored addr", 16'h0011, 16'(lba));
        r("error flagged", ADR_DATA_ERR, 8'h01);
    endtask : t_restore
    task t_sync;
        w(ADR_SOFT_SYNC, 8'h01);
        repeat (2) @(posedge mclk);
        chk("hold", 16'h1, 16'(sh));
        w(ADR_SOFT_SYNC, 8'h00);
        repeat (2) @(posedge mclk);
        chk("sync pulses", 16'h1, 16'(nst));
        chk("hold released", 16'h0, 16'(sh));
    endtask : t_sync
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    // main sequence, then a watchdog against hangs
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 0;
        t_reset;
        t_commit;
        t_store_default;
        t_store_list;
        t_restore;
        t_sync;
        end_sim;
    end
    initial begin
        #300000;
        fail_count++;
        end_sim;
    end
endmodule : tb

// [src/ecs_ctrl.sv]
// Overview of operation
// - commit copies buffers on next serial rise
// - commit bit clears itself after copying
// - twenty-three segment registers give ranges
// - sequencer executes apply and end opcodes
// - reset loads list covering 0x000..0x232
// - pending flag high while transfer runs
// - routing bit drives pending onto pin
// - error flag shows bad transfer data
// - soft reset with select low reloads
// - soft reset bit clears after one edge
// - write enable gates all store writes
// - store bit starts buffer to store copy unless set while a restore runs
// - store bit clears only after completion
// - soft sync holds, falling edge triggers
`timescale 1ns/1ps

module ecs_ctrl (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic store_sel_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ecs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [ecs_pkg::ADDR_W-1:0] buf_addr,
    input wire logic [7:0] buf_rdata,
    output logic [7:0] buf_wdata,
    output logic buf_we,
    output logic nv_req,
    output logic nv_we,
    output logic [ecs_pkg::NV_AW-1:0] nv_addr,
    output logic [7:0] nv_wdata,
    input wire logic [7:0] nv_rdata,
    input wire logic nv_ack,
    input wire logic nv_err,
    output logic active_load,
    output logic soft_rst_pulse,
    output logic sync_hold,
    output logic sync_trig,
    input wire logic status_other,
    output logic status_pin,
    output logic xfer_pending
);
    import ecs_pkg::*;

    // ------------------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------------------
    ecs_regs_t r_q;                             // registered state
    ecs_regs_t r_d;                             // next state
    logic sclk_rise;                            // synchronised serial clock rise
    logic sel_low;                              // synchronised store-select low
    logic [7:0] cur;                            // current segment entry
    logic [7:0] nxt1;                           // entry after current
    logic [7:0] nxt2;                           // second entry after current
    logic nv_block;                             // store write refused

    // segment entry with end-of-data beyond the list
    function automatic logic [7:0] seg_at(input logic [SEG_N-1:0][7:0] s, input logic [IDX_W:0] i);
        if (i < IDX_W'(SEG_N) + (IDX_W+1)'(0)) begin
            seg_at = s[i[IDX_W-1:0]];
        end else begin
            seg_at = OP_END;
        end
    endfunction : seg_at

    // register write hit
    function automatic logic hit(input logic wr, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        hit = wr && (a == b);
    endfunction : hit

    localparam ecs_regs_t REGS_RESET = '{
        st: ST_IDLE, seg: SEG_DEFAULT, idx: '0, cnt: '0, dir_store: 1'b0,
        buf_addr: '0, nv_addr: '0, data: 8'h00, commit: 1'b0, active_load: 1'b0,
        route: RST_ROUTE, soft_sync: RST_SOFT_SYNC, sync_trig: 1'b0, wren: RST_WREN,
        soft_rst: 1'b0, soft_pulse: 1'b0, restore_req: 1'b0, store: 1'b0, err: 1'b0,
        rdata: 8'h00, sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_s3: 1'b0, sel_s1: 1'b1, sel_s2: 1'b1
    };

    assign sclk_rise = r_q.sclk_s2 && !r_q.sclk_s3;
    assign sel_low = !r_q.sel_s2;
    assign cur = seg_at(r_q.seg, {1'b0, r_q.idx});
    assign nxt1 = seg_at(r_q.seg, {1'b0, r_q.idx} + (IDX_W+1)'(1));
    assign nxt2 = seg_at(r_q.seg, {1'b0, r_q.idx} + (IDX_W+1)'(2));
    assign nv_block = r_q.dir_store && !r_q.wren;

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign reg_rdata = r_q.rdata;
    assign buf_addr = r_q.buf_addr;
    assign buf_wdata = r_q.data;
    assign buf_we = (r_q.st == ST_BUFW);
    assign nv_req = (r_q.st == ST_NV) && !nv_block;
    assign nv_we = r_q.dir_store;
    assign nv_addr = r_q.nv_addr;
    assign nv_wdata = r_q.data;
    assign active_load = r_q.active_load;
    assign soft_rst_pulse = r_q.soft_pulse;
    assign sync_hold = r_q.soft_sync;
    assign sync_trig = r_q.sync_trig;
    assign xfer_pending = (r_q.st != ST_IDLE);
    assign status_pin = r_q.route ? xfer_pending : status_other;

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        // pulses last one cycle
        r_d.active_load = 1'b0;
        r_d.sync_trig = 1'b0;
        r_d.soft_pulse = 1'b0;
        // pin synchronisers
        r_d.sclk_s1 = sclk;
        r_d.sclk_s2 = r_q.sclk_s1;
        r_d.sclk_s3 = r_q.sclk_s2;
        r_d.sel_s1 = store_sel_n;
        r_d.sel_s2 = r_q.sel_s1;

        // self-clearing bits act on the serial clock rise
        if (r_q.commit && sclk_rise) begin
            r_d.commit = 1'b0;
            r_d.active_load = 1'b1;
        end
        if (r_q.soft_rst && sclk_rise) begin
            r_d.soft_rst = 1'b0;
        end

        // sequencer
        case (r_q.st)
            ST_IDLE: begin
                // store request outranks a pending restore
                if (r_q.store) begin
                    r_d.st = ST_FETCH;
                    r_d.dir_store = 1'b1;
                    r_d.idx = '0;
                    r_d.nv_addr = '0;
                    r_d.err = 1'b0;
                end else if (r_q.restore_req) begin
                    r_d.st = ST_FETCH;
                    r_d.dir_store = 1'b0;
                    r_d.restore_req = 1'b0;
                    r_d.idx = '0;
                    r_d.nv_addr = '0;
                    r_d.err = 1'b0;
                end
            end
            ST_FETCH: begin
                // walk entries in ascending order
                if (cur == OP_END) begin
                    r_d.st = ST_DONE;
                end else if (cur == OP_APPLY) begin
                    r_d.active_load = 1'b1;
                    r_d.idx = r_q.idx + IDX_W'(1);
                end else if (!cur[BIT_OPCODE]) begin
                    // range: count-1, address high nibble, address low byte
                    r_d.cnt = cur[CNT_W-1:0];
                    r_d.buf_addr = {nxt1[3:0], nxt2};
                    r_d.idx = r_q.idx + IDX_W'(3);
                    r_d.st = ST_LOAD;
                end else begin
                    r_d.idx = r_q.idx + IDX_W'(1);         // unknown opcode skipped
                end
            end
            ST_LOAD: begin
                // buffer byte is valid with its address
                if (r_q.dir_store) begin
                    r_d.data = buf_rdata;
                end
                r_d.st = ST_NV;
            end
            ST_NV: begin
                if (nv_block) begin
                    r_d.err = 1'b1;
                    r_d.st = ST_DONE;
                end else if (nv_ack) begin
                    if (nv_err) begin
                        r_d.err = 1'b1;
                    end
                    if (!r_q.dir_store) begin
                        r_d.data = nv_rdata;
                        r_d.st = ST_BUFW;
                    end else begin
                        r_d.nv_addr = r_q.nv_addr + NV_AW'(1);
                        r_d.buf_addr = r_q.buf_addr + ADDR_W'(1);
                        r_d.cnt = r_q.cnt - CNT_W'(1);
                        r_d.st = (r_q.cnt == '0) ? ST_FETCH : ST_LOAD;
                    end
                end
            end
            ST_BUFW: begin
                // buffer written this cycle, advance
                r_d.nv_addr = r_q.nv_addr + NV_AW'(1);
                r_d.buf_addr = r_q.buf_addr + ADDR_W'(1);
                r_d.cnt = r_q.cnt - CNT_W'(1);
                r_d.st = (r_q.cnt == '0) ? ST_FETCH : ST_LOAD;
            end
            ST_DONE: begin
                r_d.store = 1'b0;
                r_d.st = ST_IDLE;
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase

        // register writes; a commit or soft reset set wins over the same-cycle clear
        if (hit(reg_wr, reg_addr, ADR_COMMIT) && reg_wdata[BIT_FLAG]) begin
            r_d.commit = 1'b1;
        end
        if (hit(reg_wr, reg_addr, ADR_STATUS_ROUTE)) begin
            r_d.route = reg_wdata[BIT_ROUTE];
        end
        if (hit(reg_wr, reg_addr, ADR_SOFT_SYNC)) begin
            r_d.soft_sync = reg_wdata[BIT_FLAG];
            r_d.sync_trig = r_q.soft_sync && !reg_wdata[BIT_FLAG];
        end
        if (reg_wr && reg_addr >= ADR_SEG_FIRST && reg_addr <= ADR_SEG_LAST && !xfer_pending) begin
            r_d.seg[IDX_W'(reg_addr - ADR_SEG_FIRST)] = reg_wdata;
        end
        if (hit(reg_wr, reg_addr, ADR_RST_WREN)) begin
            r_d.wren = reg_wdata[BIT_WREN];
            if (reg_wdata[BIT_SOFT_RST]) begin
                r_d.soft_rst = 1'b1;
                if (sel_low) begin
                    r_d.soft_pulse = 1'b1;
                    r_d.restore_req = 1'b1;
                end
            end
        end
        if (hit(reg_wr, reg_addr, ADR_STORE_TRIG) && reg_wdata[BIT_FLAG] && r_q.wren && !r_q.store) begin
            r_d.store = 1'b1;
        end

        // register reads
        if (reg_rd) begin
            r_d.rdata = 8'h00;
            if (reg_addr == ADR_STATUS_ROUTE) begin
                r_d.rdata[BIT_ROUTE] = r_q.route;
            end else if (reg_addr == ADR_SOFT_SYNC) begin
                r_d.rdata[BIT_FLAG] = r_q.soft_sync;
            end else if (reg_addr == ADR_COMMIT) begin
                r_d.rdata[BIT_FLAG] = r_q.commit;
            end else if (reg_addr >= ADR_SEG_FIRST && reg_addr <= ADR_SEG_LAST) begin
                r_d.rdata = r_q.seg[IDX_W'(reg_addr - ADR_SEG_FIRST)];
            end else if (reg_addr == ADR_XFER_STATUS) begin
                r_d.rdata[BIT_FLAG] = xfer_pending;
            end else if (reg_addr == ADR_DATA_ERR) begin
                r_d.rdata[BIT_FLAG] = r_q.err;
            end else if (reg_addr == ADR_RST_WREN) begin
                r_d.rdata[BIT_SOFT_RST] = r_q.soft_rst;
                r_d.rdata[BIT_WREN] = r_q.wren;
            end else if (reg_addr == ADR_STORE_TRIG) begin
                r_d.rdata[BIT_FLAG] = r_q.store;
            end
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_q <= REGS_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_COMMIT_COPY: assert property ((r_q.commit && sclk_rise && !reg_wr) |=> (active_load && !r_q.commit))
        else $error("commit did not copy on serial rise");
    AST_COMMIT_HOLD: assert property ((r_q.commit && !sclk_rise) |=> r_q.commit)
        else $error("commit bit cleared without serial rise");
    AST_SEG_WRITE: assert property ((reg_wr && reg_addr == ADR_SEG_FIRST && !xfer_pending) |=>
        (r_q.seg[0] == $past(reg_wdata)))
        else $error("segment entry write lost");
    AST_APPLY_OP: assert property ((r_q.st == ST_FETCH && cur == OP_APPLY) |=> active_load)
        else $error("apply opcode did not pulse load");
    AST_END_OP: assert property ((r_q.st == ST_FETCH && cur == OP_END) |=> (r_q.st == ST_DONE) ##1 !xfer_pending)
        else $error("end opcode did not finish sequence");
    AST_PENDING_START: assert property ((r_q.st == ST_IDLE && (r_q.store || r_q.restore_req)) |=> xfer_pending)
        else $error("pending flag not raised at start");
    AST_STATUS_ROUTE: assert property (r_q.route |-> (status_pin == xfer_pending))
        else $error("status pin does not show pending flag");
    AST_DATA_ERR: assert property ((nv_req && nv_ack && nv_err) |=> r_q.err)
        else $error("store error not flagged");
    AST_SOFT_RST: assert property ((hit(reg_wr, reg_addr, ADR_RST_WREN) && reg_wdata[BIT_SOFT_RST] && sel_low)
        |=> (soft_rst_pulse && r_q.restore_req))
        else $error("soft reset did not request reload");
    AST_SOFT_CLR: assert property ((r_q.soft_rst && sclk_rise && !reg_wr) |=> !r_q.soft_rst)
        else $error("soft reset bit did not self-clear");
    AST_WREN: assert property ((hit(reg_wr, reg_addr, ADR_STORE_TRIG) && !r_q.wren && !r_q.store)
        |=> !r_q.store)
        else $error("store trigger taken while protected");
    AST_STORE_START: assert property ((hit(reg_wr, reg_addr, ADR_STORE_TRIG) && reg_wdata[BIT_FLAG] && r_q.wren
        && r_q.st == ST_IDLE && !r_q.store) |=> ##1 (r_q.st == ST_FETCH && r_q.dir_store))
        else $error("store bit did not start sequence");
    AST_STORE_CLR: assert property ($fell(r_q.store) |-> $past(r_q.st) == ST_DONE)
        else $error("store bit cleared before completion");
    AST_SYNC_EDGE: assert property ((hit(reg_wr, reg_addr, ADR_SOFT_SYNC) && r_q.soft_sync && !reg_wdata[BIT_FLAG])
        |=> (sync_trig && !sync_hold))
        else $error("soft sync fall did not trigger");
    AST_SEG_DEFAULT: assert property ($past(rst) |-> (r_q.seg == SEG_DEFAULT))
        else $error("segment list not at default after reset");

    COV_STORE: cover property ((r_q.st == ST_DONE) && r_q.dir_store);
    COV_RESTORE: cover property ((r_q.st == ST_DONE) && !r_q.dir_store);
    COV_COMMIT: cover property (active_load && r_q.st == ST_IDLE);
    COV_ERR: cover property ($rose(r_q.err));

endmodule : ecs_ctrl
